// ===== rtl/sram_core_pkg.sv
// Constants and carrier types for the sync burst SRAM core
package sram_core_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int HI_W   = 16;
  localparam int LANES  = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = 36;
  localparam int DEPTH  = 262144;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         WB_AW      = 4;
  localparam logic [3:0] CONFIG_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  // Config fields and reset value
  localparam int         CFG_FLOW_THRU_SEL_N      = 0;
  localparam int         CFG_LINEAR_ORDER_SEL_N   = 1;
  localparam int         CFG_DESELECT_LATENCY_SEL = 2;
  localparam int         CFG_W                    = 3;
  localparam logic [2:0] CFG_RESET                = 3'h7;

  // Status fields
  localparam int ST_SLEEP  = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_STEP   = 2;
  localparam int ST_LOW    = 4;
  localparam int ST_DRIVE  = 6;

  // Pin synchroniser reset: bit 0 output enable, bit 1 sleep
  localparam logic [1:0] PIN_RESET = 2'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    B_IDLE  = 3'b001,
    B_BURST = 3'b010,
    B_SLEEP = 3'b100
  } burst_state_type;

  typedef struct packed {
    logic             start;
    logic             desel;
    logic             advance;
    logic             write;
    logic [LANES-1:0] lanes;
  } cmd_type;

endpackage

// ===== rtl/sync_burst_sram_core.sv
// Sync burst SRAM core with Wishbone mode and status registers
//
// Contract
// - Sample all synchronous pins on rising edge
// - Output enable and sleep act asynchronously; the core acts at once only on output disable and sleep entry
// - Either address strobe loads counter, starts burst
// - 2-bit counter steps only when advance low
// - Linear or interleaved order by mode select
// - Fresh address accepted every cycle
// - Flow-through read bypasses output register
// - Pipeline read adds one output register stage
// - Dual-cycle deselect pipelined like a read
// - Single-cycle deselect turns outputs off immediately
// - Dual-cycle holds deselect one cycle, then off
// - Latency select picks single or dual deselect
// - Byte write writes only strobed lanes
// - Global write writes all lanes, overrides others
// - Sleep on sleep request or stopped clock; the core enters sleep only on the sleep request pin
// - Array contents kept through sleep
// - Defaults: single deselect, interleaved, pipelined
// - Write needs command and data one edge
// - Low address bits preset the burst counter
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_core
  import sram_core_pkg::*;
(
  // Clock and reset
  input  wire logic              SYS_CLK_I,
  input  wire logic              RST_I,
  // Wishbone slave
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [WB_AW-1:0]  WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  // Synchronous memory pins
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic              PROC_ADDR_STROBE_N_I,
  input  wire logic              CTRL_ADDR_STROBE_N_I,
  input  wire logic              BURST_ADVANCE_N_I,
  input  wire logic              CHIP_SELECT_PRIMARY_N_I,
  input  wire logic              ALL_LANES_WRITE_N_I,
  input  wire logic              BYTE_WRITE_EN_N_I,
  input  wire logic [LANES-1:0]  LANE_WRITE_STROBE_N_I,
  // Asynchronous pins
  input  wire logic              OUTPUT_EN_N_I,
  input  wire logic              SLEEP_REQUEST_I,
  // Data bus and sleep flag
  input  wire logic [DATA_W-1:0] DQ_I,
  output logic      [DATA_W-1:0] DQ_O,
  output logic                   DQ_OE_N_O,
  output logic                   SLEEP_O
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  burst_state_type     state_r;
  burst_state_type     state_nxt;
  cmd_type             cmd;
  logic [HI_W-1:0]     hi_r;
  logic [HI_W-1:0]     hi_nxt;
  logic [1:0]          base_r;
  logic [1:0]          base_nxt;
  logic [1:0]          step_r;
  logic [1:0]          step_nxt;
  logic [1:0]          low_r;
  logic [1:0]          low_nxt;
  logic [ADDR_W-1:0]   acc_nxt;
  logic                rd_stage_r;
  logic                rd_stage_nxt;
  logic                drive_r;
  logic                drive_nxt;
  logic                dq_oe_n_r;
  logic                dq_oe_n_nxt;
  logic                sleep_r;
  logic                sleep_nxt;
  logic [1:0]          s1_r;
  logic [1:0]          s1_nxt;
  logic [1:0]          s2_r;
  logic [1:0]          s2_nxt;
  logic [1:0]          s3_r;
  logic [1:0]          s3_nxt;
  logic [1:0]          flt_r;
  logic [1:0]          flt_nxt;
  logic [CFG_W-1:0]    cfg_r;
  logic [CFG_W-1:0]    cfg_nxt;
  logic                ack_r;
  logic                ack_nxt;
  logic [31:0]         dat_r;
  logic [31:0]         dat_nxt;
  logic [31:0]         status;
  logic [LANES-1:0]    lane_we;
  logic                strobe;
  logic                active_now;
  logic                rd_now;
  logic                flow;
  logic                linear;
  logic                deselect_latency_sel;

  assign flow   = !cfg_r[CFG_FLOW_THRU_SEL_N];
  assign linear = !cfg_r[CFG_LINEAR_ORDER_SEL_N];
  assign deselect_latency_sel    = cfg_r[CFG_DESELECT_LATENCY_SEL];

  // ----------------------------------------------------------------
  // Asynchronous pin synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    s1_nxt  = {SLEEP_REQUEST_I, OUTPUT_EN_N_I};
    s2_nxt  = s1_r;
    s3_nxt  = s2_r;
    flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    cmd         = '0;
    strobe      = !PROC_ADDR_STROBE_N_I || !CTRL_ADDR_STROBE_N_I;
    cmd.start   = strobe && !CHIP_SELECT_PRIMARY_N_I;
    cmd.desel   = strobe && CHIP_SELECT_PRIMARY_N_I;
    cmd.advance = !strobe && !BURST_ADVANCE_N_I && state_r == B_BURST;
    if (!ALL_LANES_WRITE_N_I) begin
      cmd.lanes = {LANES{1'b1}};
    end else if (!BYTE_WRITE_EN_N_I) begin
      cmd.lanes = ~LANE_WRITE_STROBE_N_I;
    end else begin
      cmd.lanes = '0;
    end
    active_now = !sleep_r
                 && (cmd.start || (!strobe && state_r == B_BURST));
    cmd.write  = active_now && (|cmd.lanes)
                 && !(cmd.start && !PROC_ADDR_STROBE_N_I);
    rd_now     = active_now && !cmd.write;
    lane_we    = cmd.write ? cmd.lanes : '0;
  end

  // ----------------------------------------------------------------
  // Burst state and address counter
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      B_SLEEP: begin
        if (!sleep_r) begin
          state_nxt = B_IDLE;
        end
      end
      B_IDLE, B_BURST: begin
        if (sleep_r) begin
          state_nxt = B_SLEEP;
        end else if (cmd.start) begin
          state_nxt = B_BURST;
        end else if (cmd.desel) begin
          state_nxt = B_IDLE;
        end
      end
      default: begin
        state_nxt = B_IDLE;
      end
    endcase
    hi_nxt   = hi_r;
    base_nxt = base_r;
    step_nxt = step_r;
    if (cmd.start && !sleep_r) begin
      hi_nxt   = ADDR_I[ADDR_W-1:2];
      base_nxt = ADDR_I[1:0];
      step_nxt = 2'h0;
    end else if (cmd.advance && !sleep_r) begin
      step_nxt = 2'(step_r + 2'h1);
    end
    if (linear) begin
      low_nxt = 2'(base_nxt + step_nxt);
    end else begin
      low_nxt = base_nxt ^ step_nxt;
    end
    acc_nxt = {hi_nxt, low_nxt};
  end

  // ----------------------------------------------------------------
  // Output drive and deselect latency
  // ----------------------------------------------------------------
  always_comb begin
    rd_stage_nxt = rd_now;
    if (flow) begin
      drive_nxt = rd_now;
    end else begin
      drive_nxt = rd_stage_r && !cmd.write && !sleep_r
                  && !(deselect_latency_sel && cmd.desel);
    end
    dq_oe_n_nxt = !drive_nxt || flt_r[0] || sleep_r;
    sleep_nxt   = flt_r[1];
  end

  // ----------------------------------------------------------------
  // Wishbone registers
  // ----------------------------------------------------------------
  always_comb begin
    status                          = '0;
    status[ST_SLEEP]                = sleep_r;
    status[ST_ACTIVE]               = state_r == B_BURST;
    status[ST_STEP+1:ST_STEP]       = step_r;
    status[ST_LOW+1:ST_LOW]         = low_r;
    status[ST_DRIVE]                = drive_r;
    ack_nxt = WB_CYC_I && WB_STB_I && !ack_r;
    cfg_nxt = cfg_r;
    if (WB_CYC_I && WB_STB_I && WB_WE_I && ack_r && WB_SEL_I[0]
        && WB_ADR_I == CONFIG_OFS) begin
      cfg_nxt = WB_DAT_I[CFG_W-1:0];
    end
    dat_nxt = '0;
    if (ack_nxt && !WB_WE_I) begin
      case (WB_ADR_I)
        CONFIG_OFS: dat_nxt = {29'h0, cfg_r};
        STATUS_OFS: dat_nxt = status;
        default:    dat_nxt = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r    <= B_IDLE;
      hi_r       <= '0;
      base_r     <= 2'h0;
      step_r     <= 2'h0;
      low_r      <= 2'h0;
      rd_stage_r <= 1'b0;
      drive_r    <= 1'b0;
      s1_r       <= PIN_RESET;
      s2_r       <= PIN_RESET;
      s3_r       <= PIN_RESET;
      flt_r      <= PIN_RESET;
      cfg_r      <= CFG_RESET;
      ack_r      <= 1'b0;
      dat_r      <= 32'h0;
    end else begin
      state_r    <= state_nxt;
      hi_r       <= hi_nxt;
      base_r     <= base_nxt;
      step_r     <= step_nxt;
      low_r      <= low_nxt;
      rd_stage_r <= rd_stage_nxt;
      drive_r    <= drive_nxt;
      s1_r       <= s1_nxt;
      s2_r       <= s2_nxt;
      s3_r       <= s3_nxt;
      flt_r      <= flt_nxt;
      cfg_r      <= cfg_nxt;
      ack_r      <= ack_nxt;
      dat_r      <= dat_nxt;
    end
  end

  // Sleep flag, set at once by the pin
  always_ff @(posedge SYS_CLK_I or posedge RST_I
              or posedge SLEEP_REQUEST_I) begin
    if (RST_I) begin
      sleep_r <= 1'b0;
    end else if (SLEEP_REQUEST_I) begin
      sleep_r <= 1'b1;
    end else begin
      sleep_r <= sleep_nxt;
    end
  end

  // Data output enable, disabled at once by either pin
  always_ff @(posedge SYS_CLK_I or posedge RST_I
              or posedge OUTPUT_EN_N_I or posedge SLEEP_REQUEST_I) begin
    if (RST_I) begin
      dq_oe_n_r <= 1'b1;
    end else if (OUTPUT_EN_N_I || SLEEP_REQUEST_I) begin
      dq_oe_n_r <= 1'b1;
    end else begin
      dq_oe_n_r <= dq_oe_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Array lanes
  // ----------------------------------------------------------------
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] mem [DEPTH];
    logic [LANE_W-1:0] stage_r;
    logic [LANE_W-1:0] out_r;
    always_ff @(posedge SYS_CLK_I) begin
      if (lane_we[g]) begin
        mem[acc_nxt] <= DQ_I[g*LANE_W +: LANE_W];
      end
      stage_r <= mem[acc_nxt];
    end
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        out_r <= '0;
      end else if (flow) begin
        out_r <= mem[acc_nxt];
      end else begin
        out_r <= stage_r;
      end
    end
    assign DQ_O[g*LANE_W +: LANE_W] = out_r;
  end

  assign DQ_OE_N_O = dq_oe_n_r;
  assign SLEEP_O   = sleep_r;
  assign WB_ACK_O  = ack_r;
  assign WB_DAT_O  = dat_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_start_load;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    cmd.start && !sleep_r |=>
      step_r == 2'h0 && base_r == $past(ADDR_I[1:0])
      && hi_r == $past(ADDR_I[ADDR_W-1:2]);
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("burst start did not load counter");

  property p_step;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    !sleep_r && !cmd.start |=>
      step_r == ($past(cmd.advance) ? 2'($past(step_r) + 2'h1)
                                    : $past(step_r));
  endproperty
  a_step: assert property (p_step)
    else $error("burst counter stepped wrongly");

  property p_order;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    ##1 $stable(cfg_r) |->
      low_r == (linear ? 2'(base_r + step_r) : (base_r ^ step_r));
  endproperty
  a_order: assert property (p_order)
    else $error("burst address order wrong");

  property p_flow;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    flow ##0 rd_now |=> drive_r;
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow-through read not driven at once");

  property p_pipe;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    !flow && rd_now ##1 !flow |=>
      DQ_O == $past({g_lane[3].stage_r,
        g_lane[2].stage_r, g_lane[1].stage_r, g_lane[0].stage_r});
  endproperty
  a_pipe: assert property (p_pipe)
    else $error("pipelined read skipped output stage");

  property p_scd;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    !flow && deselect_latency_sel && cmd.desel |=> !drive_r;
  endproperty
  a_scd: assert property (p_scd)
    else $error("single-cycle deselect late");

  property p_dcd;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    !flow && !deselect_latency_sel && cmd.desel && rd_stage_r && !sleep_r |=>
      drive_r ##1 !drive_r || flow;
  endproperty
  a_dcd: assert property (p_dcd)
    else $error("dual-cycle deselect timing wrong");

  property p_global;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    active_now && !ALL_LANES_WRITE_N_I && PROC_ADDR_STROBE_N_I
      |-> lane_we == {LANES{1'b1}};
  endproperty
  a_global: assert property (p_global)
    else $error("global write missed a lane");

  property p_byte;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    ALL_LANES_WRITE_N_I |->
      (lane_we & ~(~LANE_WRITE_STROBE_N_I)) == '0
      && (BYTE_WRITE_EN_N_I ? lane_we == '0 : 1'b1);
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte write hit an unstrobed lane");

  property p_sleep_keep;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    sleep_r |-> lane_we == '0 && !drive_nxt;
  endproperty
  a_sleep_keep: assert property (p_sleep_keep)
    else $error("array touched during sleep");

  property p_default;
    @(posedge SYS_CLK_I)
    $past(RST_I) && !RST_I |-> cfg_r == CFG_RESET;
  endproperty
  a_default: assert property (p_default)
    else $error("mode defaults wrong after reset");

  property p_oe_off;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    $past(OUTPUT_EN_N_I) && OUTPUT_EN_N_I |-> DQ_OE_N_O;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data driven while output enable inactive");

endmodule
`default_nettype wire

// ===== sim/ctrl_ops.svh
// Command codes shared by the controller model and the testbench
localparam logic [2:0] OP_NOP = 3'h0;
localparam logic [2:0] OP_RDP = 3'h1;
localparam logic [2:0] OP_RDC = 3'h2;
localparam logic [2:0] OP_WRG = 3'h3;
localparam logic [2:0] OP_WRB = 3'h4;
localparam logic [2:0] OP_ADV = 3'h5;
localparam logic [2:0] OP_DES = 3'h6;

// ===== sim/mem_ctrl_model.sv
// Memory controller model driving the synchronous SRAM pins
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model
  import sram_core_pkg::*;
(
  // Clock and mode
  input  wire logic              clk_i,
  input  wire logic              linear_i,
  // Memory pins
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   proc_addr_strobe_n_o,
  output logic                   ctrl_addr_strobe_n_o,
  output logic                   burst_advance_n_o,
  output logic                   chip_select_primary_n_o,
  output logic                   all_lanes_write_n_o,
  output logic                   byte_write_en_n_o,
  output logic      [LANES-1:0]  lane_write_strobe_n_o,
  output logic      [DATA_W-1:0] dq_o,
  // Read marker for the bench
  output logic                   rd_cmd_o
);
  `include "ctrl_ops.svh"
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] exp_q [$];
  logic [ADDR_W-1:0] base_r;
  logic [1:0]        step_r;
  logic              rd_act;
  logic              live = 1'b1;

  initial begin
    {proc_addr_strobe_n_o, ctrl_addr_strobe_n_o, burst_advance_n_o,
     chip_select_primary_n_o, all_lanes_write_n_o, byte_write_en_n_o,
     lane_write_strobe_n_o} = '1;
    {addr_o, dq_o, rd_cmd_o, rd_act, base_r, step_r} = '0;
  end

  // ----------------------------------------------------------------
  // One command per clock, launched just after an edge
  // ----------------------------------------------------------------
  task automatic issue(input logic [2:0] op, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d,
                       input logic [LANES-1:0] ln);
    logic              st;
    logic [1:0]        lo;
    logic [DATA_W-1:0] m;
    begin
      st = op inside {OP_RDP, OP_RDC, OP_WRG, OP_WRB};
      if (st) begin
        base_r = a;
        step_r = 2'h0;
      end
      if (op == OP_ADV) begin
        step_r = step_r + 2'h1;
      end
      lo = linear_i ? base_r[1:0] + step_r : base_r[1:0] ^ step_r;
      addr_o <= st ? a : ~addr_o;
      proc_addr_strobe_n_o <= op != OP_RDP;
      ctrl_addr_strobe_n_o <= !(op inside {OP_RDC, OP_WRG, OP_WRB, OP_DES});
      burst_advance_n_o <= op != OP_ADV;
      chip_select_primary_n_o <= op == OP_DES;
      all_lanes_write_n_o <= op != OP_WRG;
      byte_write_en_n_o <= !(op inside {OP_WRG, OP_WRB});
      lane_write_strobe_n_o <= ~ln;
      dq_o <= (op inside {OP_WRG, OP_WRB}) ? d : ~dq_o;
      rd_act = (op inside {OP_RDP, OP_RDC}) ||
               (rd_act && (op inside {OP_NOP, OP_ADV}));
      rd_cmd_o <= live && rd_act;
      if (live && rd_act)
        exp_q.push_back(mem[{base_r[ADDR_W-1:2], lo}]);
      m = mem.exists(a) ? mem[a] : '0;
      for (int g = 0; g < LANES; g++) begin
        if (op == OP_WRG || ln[g])
          m[g*LANE_W +: LANE_W] = d[g*LANE_W +: LANE_W];
      end
      if (live && (op inside {OP_WRG, OP_WRB}))
        mem[a] = m;
      @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking testbench for the sync burst SRAM core
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sram_core_pkg::*;
;
  `include "ctrl_ops.svh"
  logic              clk;
  logic              rst;
  logic              cyc;
  logic              we;
  logic [WB_AW-1:0]  adr;
  logic [31:0]       wdat;
  logic [31:0]       rdat;
  logic              ack;
  logic              oe_n;
  logic              sleep_req;
  logic              asleep;
  logic              linear;
  logic              ft;
  logic              p1;
  logic              p2;
  logic [DATA_W-1:0] dq;
  logic              dq_oe_n;
  logic [ADDR_W-1:0] base;
  logic [DATA_W-1:0] d;
  logic [31:0]       wq [$];
  logic [2:0]        dsel [3] = '{3'h6, 3'h3, 3'h1};
  integer            seed = 32'h9246;
  int                fail_count = 0;
  int                checks = 0;
  wire logic [ADDR_W-1:0] m_addr;
  wire logic              m_ps;
  wire logic              m_cs;
  wire logic              m_adv;
  wire logic              m_sel;
  wire logic              m_gw;
  wire logic              m_bw;
  wire logic [LANES-1:0]  m_ln;
  wire logic [DATA_W-1:0] m_dq;
  wire logic              m_rd;

  sync_burst_sram_core i_dut (
    .SYS_CLK_I(clk), .RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .ADDR_I(m_addr),
    .PROC_ADDR_STROBE_N_I(m_ps), .CTRL_ADDR_STROBE_N_I(m_cs),
    .BURST_ADVANCE_N_I(m_adv), .CHIP_SELECT_PRIMARY_N_I(m_sel),
    .ALL_LANES_WRITE_N_I(m_gw), .BYTE_WRITE_EN_N_I(m_bw),
    .LANE_WRITE_STROBE_N_I(m_ln), .OUTPUT_EN_N_I(oe_n),
    .SLEEP_REQUEST_I(sleep_req), .DQ_I(m_dq), .DQ_O(dq),
    .DQ_OE_N_O(dq_oe_n), .SLEEP_O(asleep)
  );

  mem_ctrl_model i_ctrl (
    .clk_i(clk), .linear_i(linear), .addr_o(m_addr),
    .proc_addr_strobe_n_o(m_ps), .ctrl_addr_strobe_n_o(m_cs),
    .burst_advance_n_o(m_adv), .chip_select_primary_n_o(m_sel),
    .all_lanes_write_n_o(m_gw), .byte_write_en_n_o(m_bw),
    .lane_write_strobe_n_o(m_ln), .dq_o(m_dq), .rd_cmd_o(m_rd)
  );

  // ----------------------------------------------------------------
  // Clock, checking and verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [DATA_W-1:0] rnd36();
    logic [63:0] v;
    v = {$random(seed), $random(seed)};
    return v[DATA_W-1:0];
  endfunction

  // Result watcher
  always @(posedge clk) begin
    p1 <= m_rd;
    p2 <= p1;
    if ((ft ? p2 : p1) === 1'b1) begin
      chk(dq, i_ctrl.exp_q.pop_front());
      chk(dq_oe_n, 1'b0);
    end
    if (ack === 1'b1 && !we)
      chk(rdat, wq.pop_front());
  end

  // ----------------------------------------------------------------
  // Wishbone access and mode setting
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    if (!w)
      wq.push_back(v);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= w ? v : 32'h0;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) begin
      fail_count++;
      tally_and_finish();
    end
    cyc <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cfg(input logic [2:0] v);
    wb(1'b1, CONFIG_OFS, {29'h0, v});
    ft <= v[CFG_FLOW_THRU_SEL_N];
    linear <= !v[CFG_LINEAR_ORDER_SEL_N];
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {cyc, we, adr, wdat, oe_n, sleep_req, linear, p1, p2} = '0;
    {rst, ft} = 2'h3;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b0, CONFIG_OFS, {29'h0, CFG_RESET});
    wb(1'b0, STATUS_OFS, 32'h0);
    wb(1'b1, 4'hC, 32'hFFFF_FFFF);
    wb(1'b0, 4'hC, 32'h0);
    cfg(3'h3);
    d = rnd36();
    base = {d[ADDR_W-1:2], 2'h0};
    for (int i = 0; i < 4; i++)
      i_ctrl.issue(OP_WRG, {base[ADDR_W-1:2], 2'(i)}, rnd36(), 4'(i));
    i_ctrl.issue(OP_WRB, {base[ADDR_W-1:2], 2'h1}, rnd36(), 4'h5);
    i_ctrl.issue(OP_DES, '0, '0, '0);
    for (int i = 0; i < 4; i++)
      i_ctrl.issue(i[0] ? OP_RDP : OP_RDC, {base[ADDR_W-1:2], 2'(3 - i)},
                   '0, '0);
    i_ctrl.issue(OP_DES, '0, '0, '0);
    i_ctrl.issue(OP_NOP, '0, '0, '0);
    for (int m = 0; m < 4; m++) begin
      cfg({1'b0, m[1], m[0]});
      d = rnd36();
      i_ctrl.issue(m[0] ? OP_RDP : OP_RDC, {base[ADDR_W-1:2], d[1:0]},
                   '0, '0);
      i_ctrl.issue(OP_ADV, '0, '0, '0);
      i_ctrl.issue(OP_NOP, '0, '0, '0);
      i_ctrl.issue(OP_ADV, '0, '0, '0);
      i_ctrl.issue(OP_ADV, '0, '0, '0);
      i_ctrl.issue(OP_DES, '0, '0, '0);
      i_ctrl.issue(OP_NOP, '0, '0, '0);
    end
    foreach (dsel[j]) begin
      cfg(dsel[j]);
      i_ctrl.issue(OP_RDC, base, '0, '0);
      i_ctrl.issue(OP_DES, '0, '0, '0);
      i_ctrl.issue(OP_NOP, '0, '0, '0);
      chk(dq_oe_n, dsel[j][CFG_DESELECT_LATENCY_SEL]);
      i_ctrl.issue(OP_NOP, '0, '0, '0);
      chk(dq_oe_n, 1'b1);
    end
    i_ctrl.live = 1'b0;
    i_ctrl.issue(OP_RDC, base, '0, '0);
    repeat (3) i_ctrl.issue(OP_NOP, '0, '0, '0);
    oe_n <= 1'b1;
    #1;
    chk(dq_oe_n, 1'b1);
    @(posedge clk);
    oe_n <= 1'b0;
    repeat (5) i_ctrl.issue(OP_NOP, '0, '0, '0);
    chk(dq_oe_n, 1'b0);
    i_ctrl.issue(OP_DES, '0, '0, '0);
    sleep_req <= 1'b1;
    #1;
    chk(asleep, 1'b1);
    @(posedge clk);
    i_ctrl.issue(OP_WRG, base, rnd36(), '0);
    i_ctrl.issue(OP_DES, '0, '0, '0);
    i_ctrl.live = 1'b1;
    sleep_req <= 1'b0;
    repeat (6) @(posedge clk);
    chk(asleep, 1'b0);
    i_ctrl.issue(OP_RDC, base, '0, '0);
    i_ctrl.issue(OP_DES, '0, '0, '0);
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
